//--- bench/mrid_decoder_test.sv
// Purpose: Self-checking bench for the instruction decoder over APB.
// Assumes: One instruction cycle is four clocks; a skip or return costs two.
// Notes:   W and status are followed by hand through the sequence below.
`timescale 1ns/1ns
`include "mrid_params.svh"
module mrid_decoder_test;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic        pready, pslverr, prescaler_clear, busy;
	logic [7:0]  porta_pins, portb_pins;
	logic [31:0] rd;
	logic        err;
	logic [7:0]  pat = 8'hA5;
	int          errors = 0;
	int          tests_run = 0;
	int          pulses = 0;

	// Clock and a count of prescaler clear pulses
	always #4 pclk = ~pclk;
	always @(posedge pclk) if (prescaler_clear === 1'b1) pulses++;

	mrid_decoder dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.porta_pins(porta_pins), .portb_pins(portb_pins), .prescaler_clear(prescaler_clear), .busy(busy));
	mrid_pin_source pins (.presetn(presetn), .porta_pins(porta_pins), .portb_pins(portb_pins));

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic final_report();
		if (errors == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			errors++;
			final_report();
		end
	endtask

	task automatic expect_reg(input string name, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h00000000);
		check(name, rd, exp);
	endtask

	task automatic chk_ws(input logic [7:0] w, input logic [7:0] s);
		expect_reg("wreg", `MRID_OFS_WREG, {24'h000000, w});
		expect_reg("status", `MRID_OFS_STATUS, {24'h000000, s});
	endtask

	task automatic set_file(input logic [6:0] f, input logic [7:0] v);
		apb(1'b1, `MRID_OFS_FADDR, {25'h0000000, f});
		apb(1'b1, `MRID_OFS_FDATA, {24'h000000, v});
	endtask

	task automatic chk_file(input logic [6:0] f, input logic [7:0] v);
		apb(1'b1, `MRID_OFS_FADDR, {25'h0000000, f});
		expect_reg("fdata", `MRID_OFS_FDATA, {24'h000000, v});
	endtask

	// Start a word and count the clocks that busy stays high
	task automatic exec(input logic [13:0] w, input int tcy);
		int n;
		apb(1'b1, `MRID_OFS_INSTR, {18'h00000, w});
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (busy === 1'b1 && n < 40);
		if (busy === 1'b1) begin
			errors++;
			final_report();
		end
		check("busy clocks", 32'(n - 1), 32'(4 * tcy));
	endtask

	function automatic logic [13:0] bo(input logic [3:0] op, input logic d, input logic [6:0] f);
		return {2'b00, op, d, f};
	endfunction

	// Status reads as {timeout, powerdown, zero, digit carry, carry}
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		chk_ws(8'h00, 8'h18);
		exec({6'b110100, 8'hF8}, 2);
		chk_ws(8'hF8, 8'h18);
		set_file(7'h7F, 8'h08);
		exec(bo(4'b0111, 1'b1, 7'h7F), 1);
		chk_ws(8'hF8, 8'h1F);
		chk_file(7'h7F, 8'h00);
		set_file(7'h21, 8'h3C);
		exec(bo(4'b0101, 1'b0, 7'h21), 1);
		chk_ws(8'h38, 8'h1B);
		chk_file(7'h21, 8'h3C);
		set_file(7'h22, 8'h41);
		exec(bo(4'b0100, 1'b1, 7'h22), 1);
		chk_ws(8'h38, 8'h1B);
		chk_file(7'h22, 8'h79);
		set_file(7'h23, 8'h38);
		exec(bo(4'b0110, 1'b0, 7'h23), 1);
		chk_ws(8'h00, 8'h1F);
		set_file(7'h24, 8'h40);
		exec(bo(4'b1101, 1'b1, 7'h24), 1);
		chk_ws(8'h00, 8'h1E);
		chk_file(7'h24, 8'h81);
		exec(bo(4'b1100, 1'b0, 7'h24), 1);
		chk_ws(8'h40, 8'h1F);
		set_file(7'h25, 8'h01);
		exec(bo(4'b1011, 1'b1, 7'h25), 2);
		chk_file(7'h25, 8'h00);
		exec(bo(4'b1011, 1'b1, 7'h25), 1);
		chk_file(7'h25, 8'hFF);
		exec(bo(4'b1111, 1'b0, 7'h25), 2);
		chk_ws(8'h00, 8'h1F);
		chk_file(7'h25, 8'hFF);
		set_file(7'h26, pat);
		for (int b = 0; b < 8; b++) begin
			exec({4'b0110, 3'(b), 7'h26}, pat[b] ? 1 : 2);
			exec({4'b0111, 3'(b), 7'h26}, pat[b] ? 2 : 1);
		end
		exec({6'b110100, 8'h0F}, 2);
		exec({6'b111110, 8'h01}, 1);
		chk_ws(8'h10, 8'h1A);
		exec({6'b111111, 8'hF0}, 1);
		chk_ws(8'h00, 8'h1D);
		exec({6'b111100, 8'h10}, 1);
		chk_ws(8'h10, 8'h1B);
		exec({6'b111100, 8'h05}, 1);
		chk_ws(8'hF5, 8'h1A);
		exec({6'b111101, 8'hF5}, 1);
		chk_ws(8'h00, 8'h1F);
		exec({6'b111000, 8'h81}, 1);
		chk_ws(8'h81, 8'h1B);
		exec({6'b111010, 8'h81}, 1);
		chk_ws(8'h00, 8'h1F);
		// Port reads take the pins, the latch is never consulted
		exec({6'b110100, 8'hFF}, 2);
		exec(bo(4'b0101, 1'b0, `MRID_ADDR_PORTB), 1);
		chk_ws(8'hC3, 8'h1B);
		exec(bo(4'b0100, 1'b0, `MRID_ADDR_PORTA), 1);
		chk_ws(8'hFF, 8'h1B);
		expect_reg("pins", `MRID_OFS_PORTPIN, 32'h0000C33C);
		set_file(`MRID_ADDR_TIMER0_COUNT, 8'h00);
		apb(1'b1, `MRID_OFS_CTRL, 32'h00000000);
		exec(bo(4'b0110, 1'b1, `MRID_ADDR_TIMER0_COUNT), 1);
		// The pulse follows the write by one clock, so let it be counted first
		@(negedge pclk);
		check("prescaler clears", 32'(pulses), 32'h00000001);
		exec(bo(4'b0110, 1'b0, `MRID_ADDR_TIMER0_COUNT), 1);
		apb(1'b1, `MRID_OFS_CTRL, 32'h00000001);
		exec(bo(4'b0110, 1'b1, `MRID_ADDR_TIMER0_COUNT), 1);
		@(negedge pclk);
		check("prescaler clears", 32'(pulses), 32'h00000001);
		chk_ws(8'h00, 8'h1B);
		exec(14'h0000, 1);
		chk_ws(8'h00, 8'h1B);
		exec(`MRID_WORD_SLEEP, 1);
		chk_ws(8'h00, 8'h13);
		// A read issued mid-instruction waits, then returns the new W
		apb(1'b1, `MRID_OFS_INSTR, {18'h00000, 6'b110100, 8'h5A});
		expect_reg("wreg after stall", `MRID_OFS_WREG, 32'h0000005A);
		apb(1'b0, 12'h020, 32'h00000000);
		check("unmapped err", {31'h00000000, err}, 32'h00000001);
		check("unmapped data", rd, 32'h00000000);
		final_report();
	end
endmodule

//--- bench/mrid_pin_source.sv
// Purpose: Pin source that stands for the outside world on both ports.
// Assumes: The decoder only samples the pins and never drives them.
// Notes:   During reset the pins show inverted levels, so a stale read stands out.
`timescale 1ns/1ns
module mrid_pin_source #(
	parameter logic [7:0] LEVEL_A = 8'h3C,
	parameter logic [7:0] LEVEL_B = 8'hC3
) (
	input  wire logic       presetn,
	output logic      [7:0] porta_pins,
	output logic      [7:0] portb_pins
);
	// Unequal nibbles, so a latch value of zero cannot pass for a pin read
	assign porta_pins = presetn ? LEVEL_A : ~LEVEL_A;
	assign portb_pins = presetn ? LEVEL_B : ~LEVEL_B;
endmodule

//--- verilog/mrid_decoder.sv
// Purpose: Decode and execute one 14-bit instruction word per APB request.
// Assumes: File registers live here as a 128-byte array; port pins are inputs.
// Notes:   A write of the instruction register starts execution; busy shows progress.
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ns
`include "mrid_params.svh"

module mrid_decoder (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [7:0]  porta_pins,
	input  wire logic [7:0]  portb_pins,
	output logic             prescaler_clear,
	output logic             busy
);
	localparam logic [2:0] PHASES = `MRID_PHASES;

	logic [7:0]         file_mem [0:127];
	logic [13:0]        instr;
	logic [7:0]         wreg;
	logic [4:0]         status;
	logic [7:0]         ctrl;
	logic [6:0]         faddr;
	logic [15:0]        cycles;
	logic [2:0]         phase;
	logic               stalled;
	mrid_pkg::mrid_state_e state;

	// Field extraction shared by all byte, bit and literal operations
	wire logic                dest    = instr[7];
	wire logic [6:0]          fa      = instr[6:0];
	wire logic [2:0]          bsel    = instr[9:7];
	wire logic [7:0]          lit     = instr[7:0];
	wire logic                is_port = (fa == `MRID_ADDR_PORTA) || (fa == `MRID_ADDR_PORTB);
	// Port registers read the pins; a result aimed at a port is never written back
	wire logic [7:0]          fval    = (fa == `MRID_ADDR_PORTA) ? porta_pins :
	                                    (fa == `MRID_ADDR_PORTB) ? portb_pins : file_mem[fa];

	function automatic mrid_pkg::mrid_op_e decode(input logic [13:0] w);
		mrid_pkg::mrid_op_e op;
		op = mrid_pkg::OP_NOP;
		if (w == `MRID_WORD_SLEEP) op = mrid_pkg::OP_SLEEP;
		else if (w[13:12] == 2'b00) begin
			unique case (w[11:8])
				4'h7: op = mrid_pkg::OP_ADD_WF;
				4'h5: op = mrid_pkg::OP_AND_WF;
				4'hB: op = mrid_pkg::OP_DEC_SKIP;
				4'hF: op = mrid_pkg::OP_INC_SKIP;
				4'h4: op = mrid_pkg::OP_OR_WF;
				4'h6: op = mrid_pkg::OP_XOR_WF;
				4'hD: op = mrid_pkg::OP_ROT_L;
				4'hC: op = mrid_pkg::OP_ROT_R;
				default: op = mrid_pkg::OP_NOP;
			endcase
		end else if (w[13:12] == 2'b01) begin
			if (w[11:10] == 2'b10) op = mrid_pkg::OP_BTEST_CLR;
			else if (w[11:10] == 2'b11) op = mrid_pkg::OP_BTEST_SET;
		end else if (w[13:12] == 2'b11) begin
			if (w[11:9] == 3'b111) op = mrid_pkg::OP_ADD_LIT;
			else if (w[11:8] == 4'h8) op = mrid_pkg::OP_OR_LIT;
			else if (w[11:8] == 4'hA) op = mrid_pkg::OP_XOR_LIT;
			else if (w[11:9] == 3'b110) op = mrid_pkg::OP_SUB_LIT;
			else if (w[11:10] == 2'b01) op = mrid_pkg::OP_RET_LIT;
		end
		return op;
	endfunction

	// Nine-bit add with digit carry; subtract passes the complement and carry-in 1
	function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b, input logic ci);
		logic [4:0] lo;
		logic [8:0] full;
		lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
		full = {1'b0, a} + {1'b0, b} + {8'h00, ci};
		return {lo[4], full};
	endfunction

	wire mrid_pkg::mrid_op_e op   = decode(instr);
	wire logic [9:0]  sum_wf      = add8(wreg, fval, 1'b0);
	wire logic [9:0]  sum_lit     = add8(lit, wreg, 1'b0);
	wire logic [9:0]  dif_lit     = add8(lit, ~wreg, 1'b1);
	wire logic [7:0]  dec_v       = fval - 8'h01;
	wire logic [7:0]  inc_v       = fval + 8'h01;
	wire logic        bit_v       = fval[bsel];

	// Result, flag updates and skip decision of the current word
	logic [7:0] res;
	logic [4:0] next_status;
	logic       to_file;
	logic       wr_w;
	logic       two_cyc;
	always_comb begin
		res         = 8'h00;
		next_status = status;
		to_file     = 1'b0;
		wr_w        = 1'b0;
		two_cyc     = 1'b0;
		unique case (op)
			mrid_pkg::OP_ADD_WF: begin
				res = sum_wf[7:0];
				next_status[`MRID_ST_C]  = sum_wf[8];
				next_status[`MRID_ST_DC] = sum_wf[9];
				next_status[`MRID_ST_Z]  = (res == 8'h00);
			end
			mrid_pkg::OP_AND_WF: begin
				res = wreg & fval;
				next_status[`MRID_ST_Z] = (res == 8'h00);
			end
			mrid_pkg::OP_OR_WF: begin
				res = wreg | fval;
				next_status[`MRID_ST_Z] = (res == 8'h00);
			end
			mrid_pkg::OP_XOR_WF: begin
				res = wreg ^ fval;
				next_status[`MRID_ST_Z] = (res == 8'h00);
			end
			mrid_pkg::OP_DEC_SKIP: begin
				res     = dec_v;
				two_cyc = (dec_v == 8'h00);
			end
			mrid_pkg::OP_INC_SKIP: begin
				res     = inc_v;
				two_cyc = (inc_v == 8'h00);
			end
			mrid_pkg::OP_ROT_L: begin
				res = {fval[6:0], status[`MRID_ST_C]};
				next_status[`MRID_ST_C] = fval[7];
			end
			mrid_pkg::OP_ROT_R: begin
				res = {status[`MRID_ST_C], fval[7:1]};
				next_status[`MRID_ST_C] = fval[0];
			end
			mrid_pkg::OP_BTEST_CLR: two_cyc = !bit_v;
			mrid_pkg::OP_BTEST_SET: two_cyc = bit_v;
			mrid_pkg::OP_ADD_LIT: begin
				res  = sum_lit[7:0];
				wr_w = 1'b1;
				next_status[`MRID_ST_C]  = sum_lit[8];
				next_status[`MRID_ST_DC] = sum_lit[9];
				next_status[`MRID_ST_Z]  = (res == 8'h00);
			end
			mrid_pkg::OP_OR_LIT: begin
				res  = lit | wreg;
				wr_w = 1'b1;
				next_status[`MRID_ST_Z] = (res == 8'h00);
			end
			mrid_pkg::OP_XOR_LIT: begin
				res  = lit ^ wreg;
				wr_w = 1'b1;
				next_status[`MRID_ST_Z] = (res == 8'h00);
			end
			mrid_pkg::OP_SUB_LIT: begin
				res  = dif_lit[7:0];
				wr_w = 1'b1;
				next_status[`MRID_ST_C]  = dif_lit[8];
				next_status[`MRID_ST_DC] = dif_lit[9];
				next_status[`MRID_ST_Z]  = (res == 8'h00);
			end
			mrid_pkg::OP_RET_LIT: begin
				res     = lit;
				wr_w    = 1'b1;
				two_cyc = 1'b1;
			end
			mrid_pkg::OP_SLEEP: begin
				next_status[`MRID_ST_TO] = 1'b1;
				next_status[`MRID_ST_PD] = 1'b0;
			end
			mrid_pkg::OP_NOP: res = 8'h00;
		endcase
		if (op inside {mrid_pkg::OP_ADD_WF, mrid_pkg::OP_AND_WF, mrid_pkg::OP_OR_WF,
		               mrid_pkg::OP_XOR_WF, mrid_pkg::OP_DEC_SKIP, mrid_pkg::OP_INC_SKIP,
		               mrid_pkg::OP_ROT_L, mrid_pkg::OP_ROT_R}) begin
			to_file = dest;
			wr_w    = !dest;
		end
	end

	// APB decode; the bus waits while an instruction is in flight
	wire logic acc       = psel && penable;
	wire logic hit       = paddr inside {`MRID_OFS_INSTR, `MRID_OFS_WREG, `MRID_OFS_STATUS,
	                                     `MRID_OFS_CTRL, `MRID_OFS_FADDR, `MRID_OFS_FDATA,
	                                     `MRID_OFS_PORTPIN, `MRID_OFS_CYCLES};
	wire logic bus_ok    = (state == mrid_pkg::ST_IDLE);
	// One settling cycle after a stall, so read data can catch the finished result
	wire logic ready_now = bus_ok && !stalled;
	wire logic wr_take   = acc && pwrite && ready_now && hit;
	wire logic start     = wr_take && (paddr == `MRID_OFS_INSTR);
	wire logic last_ph   = (phase == PHASES - 3'h1);
	wire logic exec      = (state == mrid_pkg::ST_RUN) && last_ph;
	wire logic file_wr   = exec && to_file && !is_port;
	wire logic tmr_wr    = exec && to_file && (fa == `MRID_ADDR_TIMER0_COUNT);
	assign pready  = ready_now;
	assign pslverr = acc && ready_now && !hit;
	assign busy    = (state != mrid_pkg::ST_IDLE);

	// Sequencer: four phases per instruction cycle, a second cycle as no-op
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= mrid_pkg::ST_IDLE;
			phase <= 3'h0;
			stalled <= 1'b0;
		end else begin
			stalled <= acc && !bus_ok;
			phase <= (state == mrid_pkg::ST_IDLE || last_ph) ? 3'h0 : phase + 3'h1;
			unique case (state)
				mrid_pkg::ST_IDLE: if (start) state <= mrid_pkg::ST_RUN;
				mrid_pkg::ST_RUN:  if (last_ph) state <= two_cyc ? mrid_pkg::ST_NOP : mrid_pkg::ST_IDLE;
				mrid_pkg::ST_NOP:  if (last_ph) state <= mrid_pkg::ST_IDLE;
			endcase
		end
	end

	// Architectural state and software-visible registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr           <= 14'h0000;
			wreg            <= `MRID_RST_WREG;
			status          <= `MRID_RST_STATUS;
			ctrl            <= 8'h00;
			faddr           <= 7'h00;
			cycles          <= 16'h0000;
			prescaler_clear <= 1'b0;
		end else begin
			prescaler_clear <= tmr_wr && !ctrl[`MRID_CTRL_PSA];
			if (exec) begin
				status <= next_status;
				if (wr_w) wreg <= res;
			end
			if (state != mrid_pkg::ST_IDLE && last_ph) cycles <= cycles + 16'h0001;
			if (wr_take) begin
				unique case (paddr)
					`MRID_OFS_INSTR:  instr  <= pwdata[13:0];
					`MRID_OFS_WREG:   wreg   <= pwdata[7:0];
					`MRID_OFS_STATUS: status <= pwdata[4:0];
					`MRID_OFS_CTRL:   ctrl   <= pwdata[7:0];
					`MRID_OFS_FADDR:  faddr  <= pwdata[6:0];
					`MRID_OFS_CYCLES: cycles <= 16'h0000;
					default:          ;
				endcase
			end
		end
	end

	// File array has no reset; the result is written only after the read above
	always_ff @(posedge pclk) begin
		if (file_wr) file_mem[fa] <= res;
		else if (wr_take && paddr == `MRID_OFS_FDATA) file_mem[faddr] <= pwdata[7:0];
	end

	// Read data registered in setup, reloaded while stalled; a word that ends on the setup edge can leave it stale
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) prdata <= 32'h0000_0000;
		else if (psel && (!penable || stalled)) begin
			unique case (paddr)
				`MRID_OFS_INSTR:   prdata <= {18'h00000, instr};
				`MRID_OFS_WREG:    prdata <= {24'h000000, wreg};
				`MRID_OFS_STATUS:  prdata <= {27'h0000000, status};
				`MRID_OFS_CTRL:    prdata <= {24'h000000, ctrl};
				`MRID_OFS_FADDR:   prdata <= {25'h0000000, faddr};
				`MRID_OFS_FDATA:   prdata <= {24'h000000, file_mem[faddr]};
				`MRID_OFS_PORTPIN: prdata <= {16'h0000, portb_pins, porta_pins};
				`MRID_OFS_CYCLES:  prdata <= {16'h0000, cycles};
				default:           prdata <= 32'h0000_0000;
			endcase
		end
	end

	// A word that neither skips nor returns must never take a second cycle
	property p_single;
		@(posedge pclk) disable iff (!presetn)
		(exec && !two_cyc) |=> state == mrid_pkg::ST_IDLE;
	endproperty
	a_single: assert property (p_single) else $error("extra cycle");

	property p_skip_len;
		@(posedge pclk) disable iff (!presetn)
		(exec && two_cyc) |=> (state == mrid_pkg::ST_NOP) [*4] ##1 state == mrid_pkg::ST_IDLE;
	endproperty
	a_skip_len: assert property (p_skip_len) else $error("skip not four phases");

	property p_tmr;
		@(posedge pclk) disable iff (!presetn)
		(tmr_wr && !ctrl[`MRID_CTRL_PSA]) |=> prescaler_clear;
	endproperty
	a_tmr: assert property (p_tmr) else $error("prescaler not cleared");

	property p_sleep;
		@(posedge pclk) disable iff (!presetn)
		(exec && op == mrid_pkg::OP_SLEEP) |=> status[`MRID_ST_TO] && !status[`MRID_ST_PD];
	endproperty
	a_sleep: assert property (p_sleep) else $error("standby flags");

	property p_nop;
		@(posedge pclk) disable iff (!presetn)
		(exec && op == mrid_pkg::OP_NOP) |=> $stable(wreg) && $stable(status) && state == mrid_pkg::ST_IDLE;
	endproperty
	a_nop: assert property (p_nop) else $error("no-op changed state");

	property p_dest;
		@(posedge pclk) disable iff (!presetn)
		(exec && op == mrid_pkg::OP_AND_WF && dest) |=> $stable(wreg);
	endproperty
	a_dest: assert property (p_dest) else $error("W written with d set");

	property p_add_z;
		@(posedge pclk) disable iff (!presetn)
		(exec && op == mrid_pkg::OP_ADD_LIT) |=> wreg == $past(res) && status[`MRID_ST_Z] == (wreg == 8'h00);
	endproperty
	a_add_z: assert property (p_add_z) else $error("literal add result");

	property p_ret;
		@(posedge pclk) disable iff (!presetn)
		(exec && op == mrid_pkg::OP_RET_LIT) |=> wreg == $past(lit) ##4 state == mrid_pkg::ST_IDLE;
	endproperty
	a_ret: assert property (p_ret) else $error("return literal");
endmodule

//--- verilog/mrid_params.svh
// Purpose: Constants for the mid-range instruction decoder.
// Assumes: Included by bare name from the decoder module and the bench.
// Notes:   Offsets are byte addresses on the APB slave port.
`ifndef MRID_PARAMS_SVH
`define MRID_PARAMS_SVH
`define MRID_OFS_INSTR     12'h000
`define MRID_OFS_WREG      12'h004
`define MRID_OFS_STATUS    12'h008
`define MRID_OFS_CTRL      12'h00C
`define MRID_OFS_FADDR     12'h010
`define MRID_OFS_FDATA     12'h014
`define MRID_OFS_PORTPIN   12'h018
`define MRID_OFS_CYCLES    12'h01C
`define MRID_RST_WREG      8'h00
`define MRID_RST_STATUS    5'h18
`define MRID_ST_C          0
`define MRID_ST_DC         1
`define MRID_ST_Z          2
`define MRID_ST_PD         3
`define MRID_ST_TO         4
`define MRID_CTRL_PSA      0
`define MRID_PHASES        3'h4
`define MRID_ADDR_TIMER0_COUNT     7'h01
`define MRID_ADDR_PORTA    7'h05
`define MRID_ADDR_PORTB    7'h06
`define MRID_WORD_SLEEP    14'h0063
`endif

//--- verilog/mrid_pkg.sv
// Purpose: Types shared by the mid-range instruction decoder.
// Assumes: Nothing beyond the constants header.
// Notes:   Operation codes name the decoded class of a 14-bit word.
package mrid_pkg;
	typedef enum logic [4:0] {
		OP_NOP, OP_ADD_WF, OP_AND_WF, OP_OR_WF, OP_XOR_WF, OP_DEC_SKIP, OP_INC_SKIP,
		OP_ROT_L, OP_ROT_R, OP_BTEST_CLR, OP_BTEST_SET, OP_ADD_LIT, OP_OR_LIT,
		OP_XOR_LIT, OP_SUB_LIT, OP_RET_LIT, OP_SLEEP
	} mrid_op_e;
	typedef enum logic [1:0] {
		ST_IDLE, ST_RUN, ST_NOP
	} mrid_state_e;
endpackage
